/* hdl/pcg_pkg.sv */
package pcg_pkg;

  // register map, byte addresses on the bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] HS_OFFSET = 8'h18;
  localparam logic [ADDR_W-1:0] LS_OFFSET = 8'h1C;

  // transfer attributes accepted by the slave
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam int TRANS_ACTIVE_BIT = 1;

  // writable bits and reset values of the two gate registers
  localparam logic [31:0] HS_MASK = 32'h000E_783D;
  localparam logic [31:0] HS_RESET = 32'h0000_0000;
  localparam logic [31:0] LS_MASK = 32'hB2E6_0AFF;
  localparam logic [31:0] LS_RESET = 32'h0000_0100;

  // high-speed gate register fields
  localparam int HS_SPI2 = 19;
  localparam int HS_ASYNC5 = 18;
  localparam int HS_ASYNC4 = 17;
  localparam int HS_SYNC1 = 14;
  localparam int HS_ATIM8 = 13;
  localparam int HS_SPI1 = 12;
  localparam int HS_ATIM1 = 11;
  localparam int HS_GPIOD = 5;
  localparam int HS_GPIOC = 4;
  localparam int HS_GPIOB = 3;
  localparam int HS_GPIOA = 2;
  localparam int HS_ALTFN = 0;

  // low-speed gate register fields
  localparam int LS_OPAMP = 31;
  localparam int LS_DAC = 29;
  localparam int LS_POWER = 28;
  localparam int LS_CAN = 25;
  localparam int LS_USB = 23;
  localparam int LS_I2C2 = 22;
  localparam int LS_I2C1 = 21;
  localparam int LS_SYNC3 = 18;
  localparam int LS_SYNC2 = 17;
  localparam int LS_WDOG = 11;
  localparam int LS_TIM9 = 9;
  localparam int LS_CMPFILT = 7;
  localparam int LS_CMP = 6;
  localparam int LS_TIM7 = 5;
  localparam int LS_TIM6 = 4;
  localparam int LS_TIM5 = 3;
  localparam int LS_TIM4 = 2;
  localparam int LS_TIM3 = 1;
  localparam int LS_TIM2 = 0;

  // register selected by a bus transfer
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_HS = 2'b01,
    SEL_LS = 2'b10
  } pcg_sel_t;

  // complete rising-edge state of the block
  typedef struct packed {
    logic [31:0] hs;
    logic [31:0] ls;
    logic dph_write;
    pcg_sel_t dph_sel;
    logic [31:0] rdata;
  } pcg_state_t;

endpackage

/* hdl/pcg_clock_gate.sv */
module pcg_clock_gate (
  input wire logic i_clk, // system clock, 100 MHz
  input wire logic i_reset, // synchronous reset, active high
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic i_hsel, // slave select
  input wire logic [31:0] i_haddr, // byte address
  input wire logic [1:0] i_htrans, // transfer type
  input wire logic i_hwrite, // write when high
  input wire logic [2:0] i_hsize, // transfer size
  input wire logic [31:0] i_hwdata, // write data
  input wire logic i_hready, // bus ready
  output logic [31:0] o_hrdata, // read data
  output logic o_hreadyout, // slave ready
  output logic o_hresp, // always okay
  output logic o_second_spi_clock_gate, // gated clocks, high-speed group
  output logic o_fifth_async_port_clock_gate,
  output logic o_fourth_async_port_clock_gate,
  output logic o_first_sync_async_port_clock_gate,
  output logic o_advanced_timer_eight_clock_gate,
  output logic o_first_spi_clock_gate,
  output logic o_advanced_timer_one_clock_gate,
  output logic o_gpio_port_d_clock_gate,
  output logic o_gpio_port_c_clock_gate,
  output logic o_gpio_port_b_clock_gate,
  output logic o_gpio_port_a_clock_gate,
  output logic o_alt_function_logic_clock_gate,
  output logic o_op_amp_clock_gate, // gated clocks, low-speed group
  output logic o_dac_interface_clock_gate,
  output logic o_power_interface_clock_gate,
  output logic o_can_controller_clock_gate,
  output logic o_usb_controller_clock_gate,
  output logic o_second_i2c_clock_gate,
  output logic o_first_i2c_clock_gate,
  output logic o_third_sync_async_port_clock_gate,
  output logic o_second_sync_async_port_clock_gate,
  output logic o_window_watchdog_clock_gate,
  output logic o_timer_nine_clock_gate,
  output logic o_comparator_filter_clock_gate,
  output logic o_comparator_clock_gate,
  output logic o_timer_seven_clock_gate,
  output logic o_timer_six_clock_gate,
  output logic o_timer_five_clock_gate,
  output logic o_timer_four_clock_gate,
  output logic o_timer_three_clock_gate,
  output logic o_timer_two_clock_gate
);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode, shared by reads and writes

  function automatic pcg_pkg::pcg_sel_t decode_sel(input logic [31:0] addr);
    if (addr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::HS_OFFSET) begin
      decode_sel = pcg_pkg::SEL_HS;
    end else if (addr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::LS_OFFSET) begin
      decode_sel = pcg_pkg::SEL_LS;
    end else begin
      decode_sel = pcg_pkg::SEL_NONE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave and gate registers

  pcg_pkg::pcg_state_t state_r;
  pcg_pkg::pcg_state_t state_nxt;
  logic addr_phase;
  logic wr_commit;

  // a transfer is taken only while the clock enable lets state move
  assign addr_phase = i_hsel && i_htrans[pcg_pkg::TRANS_ACTIVE_BIT] && i_hready && i_ce;
  assign wr_commit = state_r.dph_write && i_ce;

  // wait states only while frozen, so a frozen block loses no transfer
  assign o_hreadyout = i_ce;
  assign o_hresp = 1'b0;
  assign o_hrdata = state_r.rdata;

  // next state: writes land in the data phase, read data is taken from
  // the next value so a read right behind a write sees the new contents
  always_comb begin
    state_nxt = state_r;
    if (wr_commit && state_r.dph_sel == pcg_pkg::SEL_HS) begin
      // reserved bits are held at reset whatever software writes
      state_nxt.hs = (i_hwdata & pcg_pkg::HS_MASK)
                     | (pcg_pkg::HS_RESET & ~pcg_pkg::HS_MASK);
    end
    if (wr_commit && state_r.dph_sel == pcg_pkg::SEL_LS) begin
      state_nxt.ls = (i_hwdata & pcg_pkg::LS_MASK)
                     | (pcg_pkg::LS_RESET & ~pcg_pkg::LS_MASK);
    end
    if (i_ce) begin
      state_nxt.dph_write = 1'b0;
      state_nxt.dph_sel = pcg_pkg::SEL_NONE;
    end
    if (addr_phase) begin
      // only whole words are accepted; other sizes act as unmapped
      state_nxt.dph_sel = (i_hsize == pcg_pkg::SIZE_WORD) ? decode_sel(i_haddr)
                                                         : pcg_pkg::SEL_NONE;
      state_nxt.dph_write = i_hwrite;
      if (i_hwrite) begin
        state_nxt.rdata = state_r.rdata;
      end else if (state_nxt.dph_sel == pcg_pkg::SEL_HS) begin
        state_nxt.rdata = state_nxt.hs;
      end else if (state_nxt.dph_sel == pcg_pkg::SEL_LS) begin
        state_nxt.rdata = state_nxt.ls;
      end else begin
        state_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // state register; nothing but reset and a bus write moves the enables
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r.hs <= pcg_pkg::HS_RESET;
      state_r.ls <= pcg_pkg::LS_RESET;
      state_r.dph_write <= 1'b0;
      state_r.dph_sel <= pcg_pkg::SEL_NONE;
      state_r.rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // glitch-free gating: enables are retimed on the falling edge, so they
  // only change while the clock is low and every pulse passed is whole

  logic [31:0] hs_en_neg_r;
  logic [31:0] ls_en_neg_r;
  logic [31:0] hs_gclk;
  logic [31:0] ls_gclk;

  // the falling-edge copy follows the register even when frozen
  always_ff @(negedge i_clk) begin
    if (i_reset) begin
      hs_en_neg_r <= pcg_pkg::HS_RESET;
      ls_en_neg_r <= pcg_pkg::LS_RESET & pcg_pkg::LS_MASK;
    end else begin
      hs_en_neg_r <= state_r.hs & pcg_pkg::HS_MASK;
      ls_en_neg_r <= state_r.ls & pcg_pkg::LS_MASK;
    end
  end

  // one and gate per enable bit
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_gate
      assign hs_gclk[g] = i_clk & hs_en_neg_r[g];
      assign ls_gclk[g] = i_clk & ls_en_neg_r[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // high-speed group clocks

  assign o_second_spi_clock_gate = hs_gclk[pcg_pkg::HS_SPI2];
  assign o_fifth_async_port_clock_gate = hs_gclk[pcg_pkg::HS_ASYNC5];
  assign o_fourth_async_port_clock_gate = hs_gclk[pcg_pkg::HS_ASYNC4];
  assign o_first_sync_async_port_clock_gate = hs_gclk[pcg_pkg::HS_SYNC1];
  assign o_advanced_timer_eight_clock_gate = hs_gclk[pcg_pkg::HS_ATIM8];
  assign o_first_spi_clock_gate = hs_gclk[pcg_pkg::HS_SPI1];
  assign o_advanced_timer_one_clock_gate = hs_gclk[pcg_pkg::HS_ATIM1];
  assign o_gpio_port_d_clock_gate = hs_gclk[pcg_pkg::HS_GPIOD];
  assign o_gpio_port_c_clock_gate = hs_gclk[pcg_pkg::HS_GPIOC];
  assign o_gpio_port_b_clock_gate = hs_gclk[pcg_pkg::HS_GPIOB];
  assign o_gpio_port_a_clock_gate = hs_gclk[pcg_pkg::HS_GPIOA];
  assign o_alt_function_logic_clock_gate = hs_gclk[pcg_pkg::HS_ALTFN];

  ////////////////////////////////////////////////////////////////////////////////
  // low-speed group clocks

  assign o_op_amp_clock_gate = ls_gclk[pcg_pkg::LS_OPAMP];
  assign o_dac_interface_clock_gate = ls_gclk[pcg_pkg::LS_DAC];
  assign o_power_interface_clock_gate = ls_gclk[pcg_pkg::LS_POWER];
  assign o_can_controller_clock_gate = ls_gclk[pcg_pkg::LS_CAN];
  assign o_usb_controller_clock_gate = ls_gclk[pcg_pkg::LS_USB];
  assign o_second_i2c_clock_gate = ls_gclk[pcg_pkg::LS_I2C2];
  assign o_first_i2c_clock_gate = ls_gclk[pcg_pkg::LS_I2C1];
  assign o_third_sync_async_port_clock_gate = ls_gclk[pcg_pkg::LS_SYNC3];
  assign o_second_sync_async_port_clock_gate = ls_gclk[pcg_pkg::LS_SYNC2];
  assign o_window_watchdog_clock_gate = ls_gclk[pcg_pkg::LS_WDOG];
  assign o_timer_nine_clock_gate = ls_gclk[pcg_pkg::LS_TIM9];
  assign o_comparator_filter_clock_gate = ls_gclk[pcg_pkg::LS_CMPFILT];
  assign o_comparator_clock_gate = ls_gclk[pcg_pkg::LS_CMP];
  assign o_timer_seven_clock_gate = ls_gclk[pcg_pkg::LS_TIM7];
  assign o_timer_six_clock_gate = ls_gclk[pcg_pkg::LS_TIM6];
  assign o_timer_five_clock_gate = ls_gclk[pcg_pkg::LS_TIM5];
  assign o_timer_four_clock_gate = ls_gclk[pcg_pkg::LS_TIM4];
  assign o_timer_three_clock_gate = ls_gclk[pcg_pkg::LS_TIM3];
  assign o_timer_two_clock_gate = ls_gclk[pcg_pkg::LS_TIM2];

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  // high-speed register comes out of reset with every clock stopped
  hs_reset_val_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(i_reset) |-> state_r.hs == pcg_pkg::HS_RESET)
    else $error("high-speed gate register not zero after reset");

  // low-speed register comes out of reset at its documented value
  ls_reset_val_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $fell(i_reset) |-> state_r.ls == pcg_pkg::LS_RESET)
    else $error("low-speed gate register wrong after reset");

  // reserved positions never leave their reset values
  reserved_bits_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ((state_r.hs & ~pcg_pkg::HS_MASK) == (pcg_pkg::HS_RESET & ~pcg_pkg::HS_MASK))
    && ((state_r.ls & ~pcg_pkg::LS_MASK) == (pcg_pkg::LS_RESET & ~pcg_pkg::LS_MASK)))
    else $error("reserved gate bit changed");

  // a write to 0x18 lands on the next edge
  hs_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (addr_phase && i_hwrite && i_hsize == pcg_pkg::SIZE_WORD
     && i_haddr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::HS_OFFSET) ##1 i_ce
    |=> state_r.hs == ($past(i_hwdata) & pcg_pkg::HS_MASK))
    else $error("high-speed gate write not stored");

  // a write to 0x1c lands on the next edge
  ls_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (addr_phase && i_hwrite && i_hsize == pcg_pkg::SIZE_WORD
     && i_haddr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::LS_OFFSET) ##1 i_ce
    |=> state_r.ls[pcg_pkg::LS_OPAMP] == $past(i_hwdata[31])
        && state_r.ls[pcg_pkg::LS_TIM2] == $past(i_hwdata[0]))
    else $error("low-speed gate write not stored");

  // without a committed write the enables hold
  enables_hold_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !wr_commit |=> $stable(state_r.hs) && $stable(state_r.ls))
    else $error("gate register moved without a write");

  // a read of 0x1c returns the register in the data phase
  ls_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (addr_phase && !i_hwrite && i_hsize == pcg_pkg::SIZE_WORD
     && i_haddr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::LS_OFFSET)
    |=> o_hrdata == state_r.ls)
    else $error("low-speed read data wrong");

  // the retimed enables match the register at every rising edge
  gate_track_a: assert property (@(posedge i_clk) disable iff (i_reset)
    $past(i_reset) == 1'b0 |-> hs_en_neg_r == (state_r.hs & pcg_pkg::HS_MASK)
                              && ls_en_neg_r == (state_r.ls & pcg_pkg::LS_MASK))
    else $error("gate enable not retimed");

  // read data stands until the next read address phase is taken
  rdata_stands_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !(addr_phase && !i_hwrite) |=> $stable(o_hrdata))
    else $error("read data moved without a read");

  // a frozen block holds every register and the bus state
  freeze_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_ce |=> $stable(state_r))
    else $error("state moved while the clock enable was low");

  // a read of 0x18 returns the register in the data phase
  hs_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (addr_phase && !i_hwrite && i_hsize == pcg_pkg::SIZE_WORD
     && i_haddr[pcg_pkg::ADDR_W-1:0] == pcg_pkg::HS_OFFSET)
    |=> o_hrdata == state_r.hs)
    else $error("high-speed read data wrong");

  // unmapped places and narrow sizes read as zero
  refused_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (addr_phase && !i_hwrite && (i_hsize != pcg_pkg::SIZE_WORD
     || decode_sel(i_haddr) == pcg_pkg::SEL_NONE))
    |=> o_hrdata == 32'h0000_0000)
    else $error("refused read returned data");

  ////////////////////////////////////////////////////////////////////////////////
  // pulse checks on the gated outputs, sampled in the high half of the clock

  logic [31:0] hs_out;
  logic [31:0] ls_out;

  // outputs gathered back into register order, so a swapped pin shows up
  always_comb begin
    hs_out = 32'h0000_0000;
    hs_out[pcg_pkg::HS_SPI2] = o_second_spi_clock_gate;
    hs_out[pcg_pkg::HS_ASYNC5] = o_fifth_async_port_clock_gate;
    hs_out[pcg_pkg::HS_ASYNC4] = o_fourth_async_port_clock_gate;
    hs_out[pcg_pkg::HS_SYNC1] = o_first_sync_async_port_clock_gate;
    hs_out[pcg_pkg::HS_ATIM8] = o_advanced_timer_eight_clock_gate;
    hs_out[pcg_pkg::HS_SPI1] = o_first_spi_clock_gate;
    hs_out[pcg_pkg::HS_ATIM1] = o_advanced_timer_one_clock_gate;
    hs_out[pcg_pkg::HS_GPIOD] = o_gpio_port_d_clock_gate;
    hs_out[pcg_pkg::HS_GPIOC] = o_gpio_port_c_clock_gate;
    hs_out[pcg_pkg::HS_GPIOB] = o_gpio_port_b_clock_gate;
    hs_out[pcg_pkg::HS_GPIOA] = o_gpio_port_a_clock_gate;
    hs_out[pcg_pkg::HS_ALTFN] = o_alt_function_logic_clock_gate;
  end

  // low-speed group in the same way; bit 8 has no output and stays zero
  always_comb begin
    ls_out = 32'h0000_0000;
    ls_out[pcg_pkg::LS_OPAMP] = o_op_amp_clock_gate;
    ls_out[pcg_pkg::LS_DAC] = o_dac_interface_clock_gate;
    ls_out[pcg_pkg::LS_POWER] = o_power_interface_clock_gate;
    ls_out[pcg_pkg::LS_CAN] = o_can_controller_clock_gate;
    ls_out[pcg_pkg::LS_USB] = o_usb_controller_clock_gate;
    ls_out[pcg_pkg::LS_I2C2] = o_second_i2c_clock_gate;
    ls_out[pcg_pkg::LS_I2C1] = o_first_i2c_clock_gate;
    ls_out[pcg_pkg::LS_SYNC3] = o_third_sync_async_port_clock_gate;
    ls_out[pcg_pkg::LS_SYNC2] = o_second_sync_async_port_clock_gate;
    ls_out[pcg_pkg::LS_WDOG] = o_window_watchdog_clock_gate;
    ls_out[pcg_pkg::LS_TIM9] = o_timer_nine_clock_gate;
    ls_out[pcg_pkg::LS_CMPFILT] = o_comparator_filter_clock_gate;
    ls_out[pcg_pkg::LS_CMP] = o_comparator_clock_gate;
    ls_out[pcg_pkg::LS_TIM7] = o_timer_seven_clock_gate;
    ls_out[pcg_pkg::LS_TIM6] = o_timer_six_clock_gate;
    ls_out[pcg_pkg::LS_TIM5] = o_timer_five_clock_gate;
    ls_out[pcg_pkg::LS_TIM4] = o_timer_four_clock_gate;
    ls_out[pcg_pkg::LS_TIM3] = o_timer_three_clock_gate;
    ls_out[pcg_pkg::LS_TIM2] = o_timer_two_clock_gate;
  end

  // in the high half each gated clock shows the enable of the half before
  hs_pulse_a: assert property (@(negedge i_clk) disable iff (i_reset)
    hs_out == ($past(state_r.hs) & pcg_pkg::HS_MASK))
    else $error("high-speed gated clock does not follow its enable");

  // the same for the low-speed group
  ls_pulse_a: assert property (@(negedge i_clk) disable iff (i_reset)
    ls_out == ($past(state_r.ls) & pcg_pkg::LS_MASK))
    else $error("low-speed gated clock does not follow its enable");

endmodule

/* dv/pcg_periph_model.sv */
// clock inputs of the peripheral blocks: counts pulses and flags cut-short ones
module pcg_periph_model (
  input wire logic [30:0] i_gclk, // gated clocks from the block
  output int o_count [31], // rising edges seen per clock
  output int o_glitch [31] // high pulses not exactly half a period
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  for (genvar k = 0; k < 31; k++) begin : g_load
    realtime t_rise;
    initial begin
      o_count[k] = 0;
      o_glitch[k] = 0;
      t_rise = 0.0;
    end
    // a peripheral counts every rising edge, so a short pulse would clock it wrongly
    always @(posedge i_gclk[k]) begin
      o_count[k]++;
      t_rise = $realtime;
    end
    // time zero is skipped: the first fall there is only x settling to 0
    always @(negedge i_gclk[k]) begin
      if (t_rise > 0.0 && ($realtime - t_rise > 5.01 || $realtime - t_rise < 4.99)) begin
        o_glitch[k]++;
      end
    end
  end
endmodule

/* dv/tb_peripheral_clock_gating.sv */
module tb_peripheral_clock_gating;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_reset = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hready, hresp;
  wire logic [30:0] g;
  int fail_count = 0, cmp_count = 0, cyc = 0, cnt[31], glt[31];
  bit ce_rnd = 1'b0;
  int hs_bits[12] = '{19, 18, 17, 14, 13, 12, 11, 5, 4, 3, 2, 0};
  int ls_bits[19] = '{31, 29, 28, 25, 23, 22, 21, 18, 17, 11, 9, 7, 6, 5, 4, 3, 2, 1, 0};
  logic [31:0] hs_m = 32'h0, ls_m = 32'h0000_0100, hs_msk = 32'h0, ls_msk = 32'h0;
  ////////////////////////////////////////////////////////////////////////////
  pcg_clock_gate pcg_clock_gate_i (.i_clk(i_clk), .i_reset(i_reset), .i_ce(ce), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .o_second_spi_clock_gate(g[30]), .o_fifth_async_port_clock_gate(g[29]),
    .o_fourth_async_port_clock_gate(g[28]), .o_first_sync_async_port_clock_gate(g[27]),
    .o_advanced_timer_eight_clock_gate(g[26]), .o_first_spi_clock_gate(g[25]),
    .o_advanced_timer_one_clock_gate(g[24]), .o_gpio_port_d_clock_gate(g[23]),
    .o_gpio_port_c_clock_gate(g[22]), .o_gpio_port_b_clock_gate(g[21]),
    .o_gpio_port_a_clock_gate(g[20]), .o_alt_function_logic_clock_gate(g[19]),
    .o_op_amp_clock_gate(g[18]), .o_dac_interface_clock_gate(g[17]),
    .o_power_interface_clock_gate(g[16]), .o_can_controller_clock_gate(g[15]),
    .o_usb_controller_clock_gate(g[14]), .o_second_i2c_clock_gate(g[13]),
    .o_first_i2c_clock_gate(g[12]), .o_third_sync_async_port_clock_gate(g[11]),
    .o_second_sync_async_port_clock_gate(g[10]), .o_window_watchdog_clock_gate(g[9]),
    .o_timer_nine_clock_gate(g[8]), .o_comparator_filter_clock_gate(g[7]),
    .o_comparator_clock_gate(g[6]), .o_timer_seven_clock_gate(g[5]),
    .o_timer_six_clock_gate(g[4]), .o_timer_five_clock_gate(g[3]),
    .o_timer_four_clock_gate(g[2]), .o_timer_three_clock_gate(g[1]),
    .o_timer_two_clock_gate(g[0]));
  pcg_periph_model pcg_periph_model_i (.i_gclk(g), .o_count(cnt), .o_glitch(glt));
  ////////////////////////////////////////////////////////////////////////////
  always #5 i_clk = ~i_clk;
  // random stalls through the clock enable make the master really wait for ready
  always @(posedge i_clk) begin
    ce <= ce_rnd ? ($urandom % 4 != 0) : 1'b1;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_gate(input int k, input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: gated clock %0d running %b expected %b", $time, k, got, exp);
    end
  endtask
  // one single transfer; every wait is on ready, the timeout ends a hang
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    rd = hrdata;
    cmp_word(32'(hresp), 32'h0);
  endtask
  task automatic rd_cmp(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, 3'h2, rd);
    cmp_word(rd, e);
  endtask
  // software keeps reserved positions at their reset value, bit 8 of 0x1C is one
  task automatic rnd_write(input bit hs);
    logic [31:0] d, rd;
    d = hs ? ($urandom & hs_msk) : (($urandom & ls_msk) | 32'h0000_0100);
    ahb(1'b1, hs ? 32'h18 : 32'h1C, d, 3'h2, rd);
    if (hs) hs_m = d;
    else ls_m = d;
  endtask
  // a gate counts as running when most of eight periods produced an edge
  task automatic check_gates();
    int base[31];
    bit on[31];
    repeat (2) @(posedge i_clk);
    base = cnt;
    repeat (8) @(posedge i_clk);
    foreach (on[k]) on[k] = cnt[k] - base[k] > 4;
    foreach (hs_bits[i]) begin
      cmp_gate(30-i, on[30-i], hs_m[hs_bits[i]]);
    end
    foreach (ls_bits[i]) begin
      cmp_gate(18-i, on[18-i], ls_m[ls_bits[i]]);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    int gsum;
    void'($urandom(63));
    foreach (hs_bits[i]) hs_msk[hs_bits[i]] = 1'b1;
    foreach (ls_bits[i]) ls_msk[ls_bits[i]] = 1'b1;
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd_cmp(32'h18, 32'h0);
    rd_cmp(32'h1C, 32'h0000_0100);
    check_gates();
    $display("test reset values done");
    ce_rnd = 1'b1;
    repeat (40) begin
      rnd_write($urandom % 2);
      rd_cmp(32'h18, hs_m);
      rd_cmp(32'h1C, ls_m);
    end
    ce_rnd = 1'b0;
    $display("test random read back done");
    // an unmapped place and a narrow write must leave everything as it was
    ahb(1'b1, 32'h20, $urandom, 3'h2, rd);
    rd_cmp(32'h20, 32'h0);
    ahb(1'b1, 32'h18, ~hs_m & hs_msk, 3'h1, rd);
    rd_cmp(32'h18, hs_m);
    $display("test refused transfers done");
    for (int p = 0; p < 6; p++) begin
      rnd_write(1'b1);
      rnd_write(1'b0);
      if (p < 2) begin
        hs_m = p == 0 ? 32'h0 : hs_msk;
        ls_m = p == 0 ? 32'h0000_0100 : ls_msk | 32'h0000_0100;
        ahb(1'b1, 32'h18, hs_m, 3'h2, rd);
        ahb(1'b1, 32'h1C, ls_m, 3'h2, rd);
      end
      check_gates();
    end
    gsum = 0;
    foreach (glt[k]) gsum += glt[k];
    cmp_word(32'(gsum), 32'h0);
    $display("test gated clocks done");
    complete_run();
  end
endmodule
